/* File: design/ppct_timer.sv */
// pulse period capture timer with avalon-mm register slave
//
// The Avalon-MM interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "ppct_defs.svh"
module ppct_timer
    import ppct_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic [1:0]       avs_response_o,
    input  wire logic        capture_input_pin_i,
    output logic             timer_interrupt_request_o,
    output logic             pulse_output_o
);
    // ********************
    // state
    // ********************
    typedef struct packed {
        ppct_bus_st_t     bus;
        logic [31:0]      rdata;
        logic [1:0]       resp;
        logic             clk_en;
        logic             start;
        logic             stop_req;
        logic             running;
        logic             edge_flag;
        logic             undf_flag;
        logic [2:0]       cksel;
        logic             edgpl;
        logic [2:0]       mode;
        logic [1:0]       ipf;
        logic             oena;
        logic             edgsel;
        logic             mask;
        logic             req_flag;
        logic             irq;
        logic             pout;
        logic [CNT_W-1:0] reload;
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] rbuf;
        logic             rbuf_full;
        logic             cap_pend;
        logic             reload_pend;
        logic             pin_d;
    } ppct_state_t;

    ppct_state_t state_reg;
    ppct_state_t state_next;

    ppct_tick_if tk ();

    logic        src_tick;
    logic        edge_hit;
    logic        wr_ok;
    logic        rd_acc;
    logic        wr_acc;
    logic [7:0]  wb;
    logic [31:0] rd_word;
    logic        event_any;

    // ********************
    // prescaler and input filter
    // ********************
    ppct_prescaler u_presc (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .run_i     (state_reg.clk_en),
        .tk        (tk.gen)
    );

    ppct_filter u_filt (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .tk        (tk.gen)
    );

    assign tk.filt_sel = state_reg.clk_en ? state_reg.ipf : `PPCT_IPF_OFF;
    assign tk.pin_raw  = capture_input_pin_i;

    // ********************
    // count source and edge detect
    // ********************
    // unsupported sources (low-speed, event, sub clock) never tick
    always_comb begin
        case (state_reg.cksel)
            `PPCT_CK_FCLK:      src_tick = 1'h1;
            `PPCT_CK_FCLK_DIV8: src_tick = tk.tick_div8;
            `PPCT_CK_FCLK_DIV2: src_tick = tk.tick_div2;
            default:            src_tick = 1'h0;
        endcase
    end

    // active edge on the filtered input, polarity from edge select
    assign edge_hit = state_reg.edgsel
                    ? (state_reg.pin_d & ~tk.pin_clean)
                    : (~state_reg.pin_d & tk.pin_clean);

    // ********************
    // bus decode
    // ********************
    assign rd_acc = avs_read_i && (state_reg.bus == PPCT_BUS_IDLE);
    assign wr_acc = avs_write_i && (state_reg.bus == PPCT_BUS_IDLE);
    assign wb     = avs_byteenable_i[0] ? avs_writedata_i[7:0] : 8'h00;

    // writes other than the clock enable need the clock supply on
    assign wr_ok = wr_acc && avs_byteenable_i[0] && state_reg.clk_en;

    // readback mux, reserved bits read zero
    always_comb begin
        rd_word = 32'h0000_0000;
        case (avs_address_i)
            `PPCT_OFS_CLK_EN: rd_word[`PPCT_CLKEN_BIT] = state_reg.clk_en;
            `PPCT_OFS_CONTROL: begin
                rd_word[`PPCT_CR_START_BIT]   = state_reg.start;
                rd_word[`PPCT_CR_RUNNING_BIT] = state_reg.running;
                rd_word[`PPCT_CR_EDGEF_BIT]   = state_reg.edge_flag;
                rd_word[`PPCT_CR_UNDF_BIT]    = state_reg.undf_flag;
            end
            `PPCT_OFS_MODE: begin
                rd_word[`PPCT_MR_MOD_LSB+:3]  = state_reg.mode;
                rd_word[`PPCT_MR_EDGPL_BIT]   = state_reg.edgpl;
                rd_word[`PPCT_MR_CK_LSB+:3]   = state_reg.cksel;
            end
            `PPCT_OFS_IO_CONTROL: begin
                rd_word[`PPCT_IO_EDGSEL_BIT]  = state_reg.edgsel;
                rd_word[`PPCT_IO_OENA_BIT]    = state_reg.oena;
                rd_word[`PPCT_IO_IPF_LSB+:2]  = state_reg.ipf;
            end
            `PPCT_OFS_COUNTER:   rd_word[CNT_W-1:0] = state_reg.rbuf;
            `PPCT_OFS_INT_CTRL: begin
                rd_word[`PPCT_IC_MASK_BIT]    = state_reg.mask;
                rd_word[`PPCT_IC_FLAG_BIT]    = state_reg.req_flag;
            end
            `PPCT_OFS_COUNT_NOW: rd_word[CNT_W-1:0] = state_reg.count;
            default:             rd_word = 32'h0000_0000;
        endcase
    end

    // ********************
    // next state
    // ********************
    always_comb begin
        state_next = state_reg;
        event_any  = 1'h0;

        // one-wait-state slave: accept, then answer for one cycle
        case (state_reg.bus)
            PPCT_BUS_IDLE: begin
                if (avs_read_i || avs_write_i) begin
                    state_next.bus   = PPCT_BUS_DONE;
                    state_next.rdata = avs_read_i ? rd_word : 32'h0000_0000;
                    state_next.resp  = (avs_address_i > `PPCT_OFS_COUNT_NOW) ? 2'h2 : 2'h0;
                end
            end
            PPCT_BUS_DONE: begin
                state_next.bus   = PPCT_BUS_IDLE;
                state_next.rdata = 32'h0000_0000;
                state_next.resp  = 2'h0;
            end
            default: state_next.bus = PPCT_BUS_IDLE;
        endcase

        // reading the buffer frees it for the next capture
        if (rd_acc && avs_address_i == `PPCT_OFS_COUNTER) begin
            state_next.rbuf_full = 1'h0;
        end

        // register writes
        if (wr_ok) begin
            case (avs_address_i)
                `PPCT_OFS_CONTROL: begin
                    state_next.start    = wb[`PPCT_CR_START_BIT];
                    state_next.stop_req = wb[`PPCT_CR_STOP_BIT];
                    if (!wb[`PPCT_CR_EDGEF_BIT]) state_next.edge_flag = 1'h0;
                    if (!wb[`PPCT_CR_UNDF_BIT])  state_next.undf_flag = 1'h0;
                end
                `PPCT_OFS_MODE: begin
                    state_next.mode  = wb[`PPCT_MR_MOD_LSB+:3];
                    state_next.edgpl = wb[`PPCT_MR_EDGPL_BIT];
                    state_next.cksel = wb[`PPCT_MR_CK_LSB+:3];
                end
                `PPCT_OFS_IO_CONTROL: begin
                    state_next.edgsel = wb[`PPCT_IO_EDGSEL_BIT];
                    state_next.oena   = wb[`PPCT_IO_OENA_BIT];
                    state_next.ipf    = wb[`PPCT_IO_IPF_LSB+:2];
                end
                `PPCT_OFS_COUNTER: begin
                    if (avs_byteenable_i[1]) begin
                        state_next.reload = avs_writedata_i[CNT_W-1:0];
                        if (!state_reg.running) begin
                            state_next.count = avs_writedata_i[CNT_W-1:0];
                        end
                    end
                end
                `PPCT_OFS_INT_CTRL: begin
                    state_next.mask = wb[`PPCT_IC_MASK_BIT];
                    if (!wb[`PPCT_IC_FLAG_BIT]) state_next.req_flag = 1'h0;
                end
                default: state_next.start = state_reg.start;
            endcase
        end

        // forced stop drops start and clears itself
        if (state_reg.stop_req) begin
            state_next.start    = 1'h0;
            state_next.stop_req = 1'h0;
        end
        state_next.running = state_reg.start;
        state_next.pin_d   = tk.pin_clean;

        // count engine in period measurement mode
        if (state_reg.running && state_reg.mode == `PPCT_MOD_PERIOD) begin
            if (edge_hit) begin
                state_next.cap_pend = 1'h1;
            end
            if (src_tick) begin
                if (state_reg.reload_pend) begin
                    state_next.count       = state_reg.reload;
                    state_next.reload_pend = 1'h0;
                    state_next.edge_flag   = 1'h1;
                    event_any              = 1'h1;
                end else if (state_reg.cap_pend) begin
                    if (!state_reg.rbuf_full) begin
                        state_next.rbuf      = state_reg.count;
                        state_next.rbuf_full = 1'h1;
                    end
                    state_next.cap_pend    = edge_hit;
                    state_next.reload_pend = 1'h1;
                    state_next.count       = state_reg.count - CNT_W'(1);
                end else if (state_reg.count == '0) begin
                    state_next.count     = state_reg.reload;
                    state_next.undf_flag = 1'h1;
                    state_next.pout      = ~state_reg.pout;
                    event_any            = 1'h1;
                end else begin
                    state_next.count = state_reg.count - CNT_W'(1);
                end
            end
        end else begin
            state_next.cap_pend    = 1'h0;
            state_next.reload_pend = 1'h0;
        end

        // request flag: a new event wins over a clear in the same cycle
        if (event_any) begin
            state_next.req_flag = 1'h1;
        end
        state_next.irq = state_next.req_flag & ~state_next.mask;

        // gated clock supply holds everything but the enable and the bus answer in reset
        if (!state_reg.clk_en) begin
            state_next        = '0;
            state_next.bus    = state_reg.bus == PPCT_BUS_IDLE && (avs_read_i || avs_write_i)
                              ? PPCT_BUS_DONE : PPCT_BUS_IDLE;
            state_next.rdata  = state_reg.bus == PPCT_BUS_IDLE && avs_read_i
                              ? rd_word : 32'h0000_0000;
            // unmapped places still answer with an error while gated
            state_next.resp   = state_reg.bus == PPCT_BUS_IDLE && (avs_read_i || avs_write_i)
                              && avs_address_i > `PPCT_OFS_COUNT_NOW ? 2'h2 : 2'h0;
            state_next.mask   = `PPCT_MASK_RST;
            state_next.reload = `PPCT_RELOAD_RST;
            state_next.count  = `PPCT_RELOAD_RST;
        end
        if (wr_acc && avs_byteenable_i[0] && avs_address_i == `PPCT_OFS_CLK_EN) begin
            state_next.clk_en = wb[`PPCT_CLKEN_BIT];
        end else begin
            state_next.clk_en = state_reg.clk_en;
        end
    end

    // ********************
    // registers
    // ********************
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_reg        <= '0;
            state_reg.bus    <= PPCT_BUS_IDLE;
            state_reg.mask   <= `PPCT_MASK_RST;
            state_reg.reload <= `PPCT_RELOAD_RST;
            state_reg.count  <= `PPCT_RELOAD_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs from flops; waitrequest decoded from the bus state, pulse output gated by oena
    assign avs_readdata_o            = state_reg.rdata;
    assign avs_waitrequest_o         = (state_reg.bus == PPCT_BUS_IDLE);
    assign avs_response_o            = state_reg.resp;
    assign timer_interrupt_request_o = state_reg.irq;
    assign pulse_output_o            = state_reg.pout & state_reg.oena;
endmodule : ppct_timer

/* File: design/ppct_defs.svh */
// register offsets, field positions, reset values and timing counts for the period timer
`ifndef PPCT_DEFS_SVH
`define PPCT_DEFS_SVH

// ********************
// register word offsets (byte address = index * 4)
// ********************
`define PPCT_OFS_CLK_EN       4'h0
`define PPCT_OFS_CONTROL      4'h1
`define PPCT_OFS_MODE         4'h2
`define PPCT_OFS_IO_CONTROL   4'h3
`define PPCT_OFS_COUNTER      4'h4
`define PPCT_OFS_INT_CTRL     4'h5
`define PPCT_OFS_COUNT_NOW    4'h6

// ********************
// field positions
// ********************
`define PPCT_CLKEN_BIT        0
`define PPCT_CR_START_BIT     0
`define PPCT_CR_RUNNING_BIT   1
`define PPCT_CR_STOP_BIT      2
`define PPCT_CR_EDGEF_BIT     4
`define PPCT_CR_UNDF_BIT      5
`define PPCT_MR_MOD_LSB       0
`define PPCT_MR_EDGPL_BIT     3
`define PPCT_MR_CK_LSB        4
`define PPCT_IO_EDGSEL_BIT    0
`define PPCT_IO_OENA_BIT      2
`define PPCT_IO_IPF_LSB       4
`define PPCT_IC_MASK_BIT      0
`define PPCT_IC_FLAG_BIT      1

// ********************
// encodings and reset values
// ********************
`define PPCT_MOD_PERIOD       3'h4
`define PPCT_CK_FCLK          3'h0
`define PPCT_CK_FCLK_DIV8     3'h1
`define PPCT_CK_FCLK_DIV2     3'h3
`define PPCT_IPF_OFF          2'h0
`define PPCT_IPF_FCLK         2'h1
`define PPCT_IPF_DIV8         2'h2
`define PPCT_IPF_DIV32        2'h3
`define PPCT_RELOAD_RST       16'hFFFF
`define PPCT_MASK_RST         1'h1

// ********************
// timing counts
// ********************
`define PPCT_FILT_TAPS        3
`define PPCT_PRESC_BITS       5

`endif

/* File: design/ppct_pkg.sv */
// types shared by the period timer modules
package ppct_pkg;

    typedef enum logic [1:0] {
        PPCT_BUS_IDLE,
        PPCT_BUS_DONE
    } ppct_bus_st_t;

endpackage : ppct_pkg

/* File: design/ppct_tick_if.sv */
// tick and filter carrier between the period timer modules
`timescale 1ns/1ps
interface ppct_tick_if;
    logic       tick_div2;
    logic       tick_div8;
    logic       tick_div32;
    logic [1:0] filt_sel;
    logic       pin_raw;
    logic       pin_clean;

    modport gen (output tick_div2, output tick_div8, output tick_div32,
                 input filt_sel, input pin_raw, output pin_clean);
    modport use_side (input tick_div2, input tick_div8, input tick_div32,
                      output filt_sel, output pin_raw, input pin_clean);
endinterface : ppct_tick_if

/* File: design/ppct_prescaler.sv */
// prescaler ticks for count source and input filter sampling
`timescale 1ns/1ps
`include "ppct_defs.svh"
module ppct_prescaler
    import ppct_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    input  wire logic run_i,
    ppct_tick_if.gen  tk
);
    typedef struct packed {
        logic [`PPCT_PRESC_BITS-1:0] cnt;
        logic                        d2;
        logic                        d8;
        logic                        d32;
    } ppct_presc_t;

    ppct_presc_t state_reg;
    ppct_presc_t state_next;

    // free divider, held at zero while the clock supply is gated
    always_comb begin
        state_next     = state_reg;
        state_next.cnt = run_i ? state_reg.cnt + 5'h01 : 5'h00;
        state_next.d2  = run_i && (state_reg.cnt[0] == 1'h1);
        state_next.d8  = run_i && (state_reg.cnt[2:0] == 3'h7);
        state_next.d32 = run_i && (state_reg.cnt == 5'h1F);
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign tk.tick_div2  = state_reg.d2;
    assign tk.tick_div8  = state_reg.d8;
    assign tk.tick_div32 = state_reg.d32;
endmodule : ppct_prescaler

/* File: design/ppct_filter.sv */
// digital noise filter on the capture input
`timescale 1ns/1ps
`include "ppct_defs.svh"
module ppct_filter
    import ppct_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    ppct_tick_if.gen  tk
);
    typedef struct packed {
        logic [`PPCT_FILT_TAPS-1:0] taps;
        logic                       level;
    } ppct_filt_t;

    ppct_filt_t state_reg;
    ppct_filt_t state_next;
    logic       sample;

    // sampling strobe per filter select
    always_comb begin
        case (tk.filt_sel)
            `PPCT_IPF_FCLK:  sample = 1'h1;
            `PPCT_IPF_DIV8:  sample = tk.tick_div8;
            `PPCT_IPF_DIV32: sample = tk.tick_div32;
            default:         sample = 1'h1;
        endcase
    end

    // with a filter selected, level changes only after three equal samples, so glitches die here; with the filter off it follows the pin
    always_comb begin
        state_next = state_reg;
        if (tk.filt_sel == `PPCT_IPF_OFF) begin
            state_next.level = tk.pin_raw;
            state_next.taps  = {`PPCT_FILT_TAPS{tk.pin_raw}};
        end else if (sample) begin
            state_next.taps = {state_reg.taps[`PPCT_FILT_TAPS-2:0], tk.pin_raw};
            if (&state_next.taps) begin
                state_next.level = 1'h1;
            end else if (~|state_next.taps) begin
                state_next.level = 1'h0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign tk.pin_clean = state_reg.level;
endmodule : ppct_filter

/* File: test/ppct_props.sv */
// bus answer and interrupt gating checks for the period timer
`timescale 1ns/1ps
module ppct_props
    import ppct_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    input wire logic [3:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic [1:0]  avs_response_o,
    input wire logic        timer_interrupt_request_o,
    input wire logic        pulse_output_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    // ********************
    // bus steps
    // ********************
    // a request is taken on its first cycle only, so a held one is not counted twice
    sequence s_take;
        $rose(avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence s_answer;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence

    chk_answer_one: assert property (s_take |=> s_answer)
        else $error("late bus answer");
    chk_data_idle: assert property (avs_waitrequest_o |-> avs_readdata_o == 32'h0)
        else $error("idle read data");
    chk_resp_idle: assert property (avs_waitrequest_o |-> avs_response_o == 2'h0)
        else $error("idle response");
    chk_resp_unmapped: assert property ((s_take ##0 avs_address_i > 4'h6)
        |=> avs_response_o == 2'h2 && !avs_waitrequest_o)
        else $error("unmapped no error");
    chk_resp_mapped: assert property ((s_take ##0 avs_address_i <= 4'h6)
        |=> avs_response_o == 2'h0)
        else $error("mapped error");
    chk_unmapped_zero: assert property ((s_take ##0 avs_read_i && avs_address_i > 4'h6)
        |=> avs_readdata_o == 32'h0)
        else $error("unmapped data");

    // ********************
    // interrupt and reset
    // ********************
    // mask read back as set means the request line must be quiet
    chk_mask_blocks: assert property ((!avs_waitrequest_o && avs_readdata_o[0]
        && $past(avs_read_i && avs_address_i == 4'h5)) |-> !timer_interrupt_request_o)
        else $error("masked interrupt");
    chk_reset_idle: assert property ($fell(sys_rst_i)
        |-> avs_waitrequest_o && !timer_interrupt_request_o && !pulse_output_o)
        else $error("busy after reset");
endmodule : ppct_props

/* File: test/ppct_pulse_src.sv */
// square wave source standing in for the signal on the capture input
`timescale 1ns/1ps
module ppct_pulse_src (
    input  wire logic       clk_i,
    input  wire logic       run_i,
    input  wire logic [7:0] half_i,
    input  wire logic       level_i,
    output logic            pin_o
);
    logic [7:0] cnt_reg;

    // toggles every half_i cycles; halted, the pin follows level_i for single edges
    always_ff @(posedge clk_i) begin
        if (!run_i) begin
            cnt_reg <= 8'h00;
            pin_o   <= level_i;
        end else if (cnt_reg + 8'h01 >= half_i) begin
            cnt_reg <= 8'h00;
            pin_o   <= ~pin_o;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end
endmodule : ppct_pulse_src

/* File: test/pulse_period_capture_timer_bench.sv */
// self-checking bench for the pulse period capture timer
`timescale 1ns/1ps
module pulse_period_capture_timer_bench;
    import ppct_pkg::*;
    typedef struct {logic [31:0] e; logic [31:0] m; string nm;} ppct_note_t;
    logic        clk_i, sys_rst_i, avs_read_i, avs_write_i, cap_run, cap_lvl, sel;
    logic        avs_waitrequest_o, irq, pin;
    logic [3:0]  avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, rdq;
    logic [1:0]  resp, f;
    logic [7:0]  half;
    logic [15:0] rl, m1, m2;
    int          mismatches, total_checks, h1, h2;
    ppct_note_t  notes[$];
    ppct_note_t  nt;
    logic [3:0]  rst_a [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7};
    logic [31:0] rst_v [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'hFFFF, 32'h0};

    ppct_timer #(.CNT_W(16)) u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .avs_response_o(resp), .capture_input_pin_i(pin),
        .timer_interrupt_request_o(irq), .pulse_output_o());
    ppct_pulse_src u_src (.clk_i(clk_i), .run_i(cap_run), .half_i(half), .level_i(cap_lvl),
        .pin_o(pin));

    // 250 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic summarize;
        if (mismatches == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    // one bus cycle; request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        avs_read_i      <= !w;
        avs_write_i     <= w;
        avs_address_i   <= a;
        avs_writedata_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 40);
        if (n >= 40) begin
            mismatches++;
            summarize();
        end
        rdq = avs_readdata_o;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    // a zero mask notes a read whose data is not judged
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m,
                      input string nm);
        notes.push_back('{e, m, nm});
        bus(1'b0, a, 32'h0);
    endtask : rd

    // a rising request ends the wait early; a quiet one is judged after the full span
    task automatic irq_is(input int n, input logic v);
        for (int k = 0; k < n && (v ? irq !== 1'b1 : 1'b1); k++)
            @(posedge clk_i);
        cmp("interrupt", {31'h0, v}, {31'h0, irq});
    endtask : irq_is

    // poll the request flag, then clear it with the mask kept
    task automatic wait_cap;
        int k;
        k = 0;
        do begin
            rd(4'h5, 32'h0, 32'h0, "poll");
            k++;
        end while (rdq[1] !== 1'b1 && k < 100);
        if (k >= 100) begin
            mismatches++;
            summarize();
        end
        wr(4'h5, 32'h1);
    endtask : wait_cap

    // read answers are matched against the oldest note
    always @(posedge clk_i) begin
        if (!sys_rst_i && avs_read_i && avs_waitrequest_o === 1'b0 && notes.size() > 0) begin
            nt = notes.pop_front();
            if (nt.m != 32'h0)
                cmp(nt.nm, nt.e & nt.m, avs_readdata_o & nt.m);
        end
    end

    initial begin
        {sys_rst_i, avs_read_i, avs_write_i, cap_run, cap_lvl} = 5'b10000;
        avs_address_i = 4'h0;
        avs_writedata_i = 32'h0;
        half = 8'h14;
        mismatches = 0;
        total_checks = 0;
        void'($urandom(17));
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        // ********************
        // reset values, gated writes, unmapped place
        // ********************
        for (int i = 0; i < 7; i++)
            rd(rst_a[i], rst_v[i], 32'hFFFF_FFFF, "reset value");
        wr(4'h2, 32'h4);
        rd(4'h2, 32'h0, 32'hFF, "gated mode");
        wr(4'h0, 32'h1);
        wr(4'h2, 32'h4);
        rd(4'h2, 32'h4, 32'hFF, "mode");
        // ********************
        // edge polarity and filter settings
        // ********************
        for (int k = 0; k < 5; k++) begin
            sel = (k == 4);
            f = (k < 4) ? k[1:0] : 2'h0;
            wr(4'h1, 32'h0);
            wr(4'h3, {26'h0, f, 3'h0, sel});
            cap_lvl <= sel;
            repeat (130) @(posedge clk_i);
            wr(4'h5, 32'h0);
            wr(4'h1, 32'h1);
            rd(4'h4, 32'h0, 32'h0, "free");
            @(posedge clk_i);
            cap_lvl <= ~sel;
            @(posedge clk_i);
            cap_lvl <= sel;
            irq_is(200, f == 2'h0);
            wr(4'h5, 32'h0);
            rd(4'h4, 32'h0, 32'h0, "free");
            cap_lvl <= ~sel;
            irq_is(200, 1'b1);
            wr(4'h5, 32'h0);
            rd(4'h4, 32'h0, 32'h0, "free");
            cap_lvl <= sel;
            irq_is(200, 1'b0);
        end
        // ********************
        // period capture, held buffer, masked request
        // ********************
        h1 = 20 + $urandom_range(0, 15);
        h2 = h1 + 2 + $urandom_range(0, 7);
        rl = 16'h0800 + 16'($urandom_range(0, 255));
        wr(4'h1, 32'h0);
        wr(4'h3, 32'h0);
        wr(4'h4, {16'h0, rl});
        wr(4'h5, 32'h1);
        half <= h1[7:0];
        cap_run <= 1'b1;
        wr(4'h1, 32'h1);
        wait_cap();
        rd(4'h4, 32'h0, 32'h0, "free");
        wait_cap();
        rd(4'h4, 32'h0, 32'h0, "free");
        wait_cap();
        half <= h2[7:0];
        repeat (8 * h2) @(posedge clk_i);
        rd(4'h4, 32'h0, 32'h0, "held");
        m1 = rdq[15:0];
        cmp("held period", 32'h1, {31'h0, (rl - m1 >= 2 * h1 - 2) && (rl - m1 <= 2 * h1)});
        wr(4'h5, 32'h1);
        wait_cap();
        rd(4'h4, 32'h0, 32'h0, "free");
        wait_cap();
        rd(4'h4, 32'h0, 32'h0, "period");
        m2 = rdq[15:0];
        cmp("period step", 32'(2 * (h2 - h1)), {16'h0, m1 - m2});
        cmp("masked interrupt", 32'h0, {31'h0, irq});
        // ********************
        // underflow, start and stop
        // ********************
        cap_run <= 1'b0;
        wr(4'h1, 32'h0);
        wr(4'h5, 32'h1);
        wr(4'h4, 32'h20);
        rd(4'h6, 32'h20, 32'hFFFF, "loaded count");
        wr(4'h1, 32'h1);
        repeat (60) @(posedge clk_i);
        rd(4'h1, 32'h23, 32'h23, "control");
        rd(4'h5, 32'h3, 32'h3, "request flag");
        wr(4'h1, 32'h0);
        wr(4'h4, 32'h0123);
        repeat (20) @(posedge clk_i);
        rd(4'h6, 32'h0123, 32'hFFFF, "stopped count");
        rd(4'h1, 32'h0, 32'h3, "stopped");
        // ********************
        // clock gate closed again, unmapped access
        // ********************
        wr(4'h9, 32'hFF);
        rd(4'hC, 32'h0, 32'hFFFF_FFFF, "unmapped");
        wr(4'h0, 32'h0);
        wr(4'h2, 32'h3);
        rd(4'h2, 32'h0, 32'hFF, "gated mode");
        rd(4'h5, 32'h1, 32'hFF, "gated int");
        rd(4'h6, 32'hFFFF, 32'hFFFF, "gated count");
        summarize();
    end
endmodule : pulse_period_capture_timer_bench

bind ppct_timer ppct_props u_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .avs_response_o(avs_response_o),
    .timer_interrupt_request_o(timer_interrupt_request_o), .pulse_output_o(pulse_output_o));
